// File: hdl/icc_params.svh
// Purpose: constants of the instruction clock-count model
// Assumes: included by bare name from the package and design modules
// Notes: all counts are in processor clocks
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH

`define ICC_CW 10
`define ICC_MISALIGN_CLKS 10'h003
`define ICC_BASE_DEP_CLKS 10'h001
`define ICC_INDEX_CLKS 10'h001
`define ICC_DISP_IMM_CLKS 10'h001
`define ICC_INVAL_CLKS 10'h001
`define ICC_TLB_NONE_CLKS 10'h00d
`define ICC_TLB_ONE_CLKS 10'h015
`define ICC_TLB_BOTH_CLKS 10'h01c
`define ICC_BURST_LATER_BEATS 10'h003
`define ICC_BUS_R_DEF 10'h002
`define ICC_BUS_B_DEF 10'h001
`define ICC_BUS_W_DEF 10'h002
`define ICC_BUS_R_FAST 10'h002
`define ICC_PREFIX_OP 8'h0f
`define ICC_EXT_MASK 8'hf6
`define ICC_EXT_MATCH 8'hb6
`define ICC_EXT_Z_BIT 3
`define ICC_LEA_OP 8'h8d
`define ICC_EXT_CLKS 10'h003
`define ICC_EXT_MISS_CLKS 10'h002
`define ICC_LEA_CLKS 10'h001
`define ICC_LEA_IDX_CLKS 10'h002

`endif

// File: hdl/icc_pkg.sv
// Purpose: types shared by the clock-count model modules
// Assumes: icc_params.svh supplies the count width
// Notes: none
`include "icc_params.svh"

package icc_pkg;

  typedef logic [`ICC_CW-1:0] icc_clk_t;

  typedef enum logic [1:0] {
    ICC_KIND_OTHER,
    ICC_KIND_EXT,
    ICC_KIND_LEA
  } icc_kind_e;

  typedef enum logic [1:0] {
    ICC_ST_IDLE,
    ICC_ST_STALL,
    ICC_ST_DONE
  } icc_state_e;

endpackage

// File: hdl/icc_core_if.sv
// Purpose: carrier between the model top, its decoder and its adder
// Assumes: one clock domain
// Notes: pure wiring, no logic
`timescale 1ns/100ps

interface icc_core_if;
  import icc_pkg::*;
  logic [7:0] op0;
  logic [7:0] op1;
  logic mem_form;
  logic uses_index;
  icc_kind_e kind;
  logic ext_sign;
  icc_clk_t dec_base;
  icc_clk_t dec_miss;
  logic [1:0] misalign_cnt;
  logic base_dep;
  logic push_pop_pair;
  logic disp_imm;
  logic jmp_miss;
  logic jmp_dword;
  logic jmp_burst;
  logic [1:0] wr_cnt;
  logic wbuf_full;
  logic tlb_miss;
  logic [1:0] tlb_upd;
  logic multi_unaligned;
  logic data_miss;
  icc_clk_t adj_sum;

  modport dec (input op0, op1, mem_form, uses_index,
               output kind, ext_sign, dec_base, dec_miss);
  modport adj (input kind, uses_index, misalign_cnt, base_dep, push_pop_pair,
               disp_imm, jmp_miss, jmp_dword, jmp_burst, wr_cnt, wbuf_full,
               tlb_miss, tlb_upd, multi_unaligned, data_miss,
               output adj_sum);
  modport top (output op0, op1, mem_form, uses_index, misalign_cnt, base_dep,
               push_pop_pair, disp_imm, jmp_miss, jmp_dword, jmp_burst,
               wr_cnt, wbuf_full, tlb_miss, tlb_upd, multi_unaligned, data_miss,
               input kind, ext_sign, dec_base, dec_miss, adj_sum);
endinterface // icc_core_if

// File: hdl/icc_decode.sv
// Purpose: decodes extending moves and effective-address loads
// Assumes: opcode bytes are held stable by the top while in use
// Notes: combinational; other opcodes report kind other and zero counts
`timescale 1ns/100ps
`include "icc_params.svh"

module icc_decode
  import icc_pkg::*;
(
  icc_core_if.dec bus
);
  import icc_pkg::*;

  always_comb
  begin
    bus.kind = ICC_KIND_OTHER;
    bus.ext_sign = 1'b0;
    bus.dec_base = '0;
    bus.dec_miss = '0;
    if (bus.op0 == `ICC_PREFIX_OP && (bus.op1 & `ICC_EXT_MASK) == `ICC_EXT_MATCH)
    begin
      bus.kind = ICC_KIND_EXT;
      bus.ext_sign = bus.op1[`ICC_EXT_Z_BIT];
      bus.dec_base = `ICC_EXT_CLKS;
      bus.dec_miss = bus.mem_form ? `ICC_EXT_MISS_CLKS : '0;
    end
    else if (bus.op0 == `ICC_LEA_OP)
    begin
      bus.kind = ICC_KIND_LEA;
      bus.dec_base = bus.uses_index ? `ICC_LEA_IDX_CLKS : `ICC_LEA_CLKS;
    end
  end

endmodule // icc_decode

// File: hdl/icc_adjust.sv
// Purpose: sums the fixed per-instruction clock adjustments
// Assumes: bus timing r-b-w given as parameters
// Notes: combinational; stall clocks are counted by the top instead
`timescale 1ns/100ps
`include "icc_params.svh"

module icc_adjust
  import icc_pkg::*;
#(
  parameter icc_clk_t BUS_R = `ICC_BUS_R_DEF,
  parameter icc_clk_t BUS_B = `ICC_BUS_B_DEF,
  parameter icc_clk_t BUS_W = `ICC_BUS_W_DEF
)
(
  icc_core_if.adj bus
);
  import icc_pkg::*;

  // one line fill: first read plus the later burst beats
  function automatic icc_clk_t line_fill(input icc_clk_t r, input icc_clk_t b);
    line_fill = r + b * `ICC_BURST_LATER_BEATS;
  endfunction

  function automatic icc_clk_t times(input logic [1:0] n, input icc_clk_t k);
    times = icc_clk_t'(n) * k;
  endfunction

  icc_clk_t sum;

  always_comb
  begin
    sum = times(bus.misalign_cnt, `ICC_MISALIGN_CLKS);
    if (bus.base_dep && !bus.push_pop_pair)
      sum = sum + `ICC_BASE_DEP_CLKS;
    // effective-address load already counts its index in the base clocks
    if (bus.uses_index && bus.kind != ICC_KIND_LEA)
      sum = sum + `ICC_INDEX_CLKS;
    if (bus.jmp_miss)
    begin
      sum = sum + BUS_R;
      if (bus.jmp_dword)
        sum = sum + BUS_B * `ICC_BURST_LATER_BEATS;
      if (bus.jmp_burst)
        sum = sum + line_fill(BUS_R, BUS_B);
    end
    if (bus.wbuf_full)
      sum = sum + times(bus.wr_cnt, BUS_W);
    if (bus.disp_imm)
      sum = sum + `ICC_DISP_IMM_CLKS;
    if (bus.tlb_miss)
    begin
      case (bus.tlb_upd)
        2'h0: sum = sum + `ICC_TLB_NONE_CLKS;
        2'h1: sum = sum + `ICC_TLB_ONE_CLKS;
        default: sum = sum + `ICC_TLB_BOTH_CLKS;
      endcase
    end
    if (bus.data_miss && bus.multi_unaligned)
      sum = sum + line_fill(BUS_R, BUS_B);
    bus.adj_sum = sum;
  end

endmodule // icc_adjust

// File: hdl/icc_clock_model.sv
// Purpose: per-instruction clock-count model with partial opcode decode
// Assumes: inputs synchronous to clk; one instruction in flight at a time
// Notes: total is reported once stalls seen on the live inputs have ended
//
// Contract
// - each misaligned access adds three clocks
// - base register written by previous instruction adds one, except push/pop pairs
// - index register in address calculation adds one clock
// - jump target miss adds r, plus 3b past dword, plus r+3b past burst
// - writes add w clocks only while all write buffers are full
// - displacement with immediate adds one clock
// - each contending invalidate cycle delays by one clock
// - TLB miss adds 13, 21 or 28 by accessed/dirty updates needed
// - reads and writes wait until an ongoing line fill completes; the model waits only when insn_fill_miss or insn_fill_line is set
// - unaligned multi-item read miss adds one line fill, r+3b
// - reads are extended until the external bus is available
// - prefix 0f then 1011z11w is extending move, 3 clocks, 2 miss
// - z clear means zero extension, z set means sign extension
// - opcode 8d is address load, 1 clock, 2 with index
// - bus timing is r, b, w; fastest bus is 2-1-2
`timescale 1ns/100ps
`include "icc_params.svh"

module icc_clock_model
  import icc_pkg::*;
#(
  parameter icc_pkg::icc_clk_t BUS_R = `ICC_BUS_R_DEF,
  parameter icc_pkg::icc_clk_t BUS_B = `ICC_BUS_B_DEF,
  parameter icc_pkg::icc_clk_t BUS_W = `ICC_BUS_W_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic insn_valid,
  input wire logic [7:0] insn_op0,
  input wire logic [7:0] insn_op1,
  input wire logic insn_mem_form,
  input wire icc_pkg::icc_clk_t insn_base_clks,
  input wire icc_pkg::icc_clk_t insn_miss_clks,
  input wire logic insn_data_miss,
  input wire logic [1:0] insn_misalign_cnt,
  input wire logic insn_base_dep,
  input wire logic insn_push_pop_pair,
  input wire logic insn_uses_index,
  input wire logic insn_disp_imm,
  input wire logic insn_jmp_miss,
  input wire logic insn_jmp_dword,
  input wire logic insn_jmp_burst,
  input wire logic [1:0] insn_wr_cnt,
  input wire logic insn_wbuf_full,
  input wire logic insn_tlb_miss,
  input wire logic [1:0] insn_tlb_upd,
  input wire logic insn_multi_unaligned,
  input wire logic insn_reads,
  input wire logic insn_fill_miss,
  input wire logic insn_fill_line,
  input wire logic fill_busy,
  input wire logic bus_avail,
  input wire logic inval_contend,
  output logic busy_q,
  output logic done_q,
  output icc_pkg::icc_clk_t total_clks_q,
  output icc_pkg::icc_clk_t stall_clks_q,
  output icc_pkg::icc_kind_e kind_q,
  output logic ext_sign_q
);
  import icc_pkg::*;

  icc_core_if core ();

  icc_state_e state_q;
  icc_state_e state_d;

  logic [7:0] op0_q;
  logic [7:0] op1_q;
  logic mem_form_q;
  icc_clk_t base_q;
  icc_clk_t miss_q;
  logic data_miss_q;
  logic [1:0] misalign_q;
  logic base_dep_q;
  logic push_pop_q;
  logic uses_index_q;
  logic disp_imm_q;
  logic jmp_miss_q;
  logic jmp_dword_q;
  logic jmp_burst_q;
  logic [1:0] wr_cnt_q;
  logic wbuf_full_q;
  logic tlb_miss_q;
  logic [1:0] tlb_upd_q;
  logic multi_q;
  logic reads_q;
  logic fill_miss_q;
  logic fill_line_q;

  icc_clk_t stall_cnt_q;
  logic take;
  logic fill_wait;
  logic bus_wait;
  logic hold;
  icc_clk_t base_eff;
  icc_clk_t miss_eff;
  icc_clk_t total_d;

  assign core.op0 = op0_q;
  assign core.op1 = op1_q;
  assign core.mem_form = mem_form_q;
  assign core.uses_index = uses_index_q;
  assign core.misalign_cnt = misalign_q;
  assign core.base_dep = base_dep_q;
  assign core.push_pop_pair = push_pop_q;
  assign core.disp_imm = disp_imm_q;
  assign core.jmp_miss = jmp_miss_q;
  assign core.jmp_dword = jmp_dword_q;
  assign core.jmp_burst = jmp_burst_q;
  assign core.wr_cnt = wr_cnt_q;
  assign core.wbuf_full = wbuf_full_q;
  assign core.tlb_miss = tlb_miss_q;
  assign core.tlb_upd = tlb_upd_q;
  assign core.multi_unaligned = multi_q;
  assign core.data_miss = data_miss_q;

  icc_decode u_decode (
    .bus (core.dec)
  );

  icc_adjust #(
    .BUS_R (BUS_R),
    .BUS_B (BUS_B),
    .BUS_W (BUS_W)
  ) u_adjust (
    .bus (core.adj)
  );

  // a new instruction is taken only when idle; requests while busy are dropped
  assign take = insn_valid && state_q == ICC_ST_IDLE;

  assign fill_wait = (fill_miss_q || fill_line_q) && fill_busy;
  assign bus_wait = reads_q && !bus_avail;
  assign hold = fill_wait || bus_wait || inval_contend;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      op0_q <= 8'h00;
      op1_q <= 8'h00;
      mem_form_q <= 1'b0;
      base_q <= '0;
      miss_q <= '0;
      data_miss_q <= 1'b0;
    end
    else if (take)
    begin
      op0_q <= insn_op0;
      op1_q <= insn_op1;
      mem_form_q <= insn_mem_form;
      base_q <= insn_base_clks;
      miss_q <= insn_miss_clks;
      data_miss_q <= insn_data_miss;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      misalign_q <= 2'h0;
      base_dep_q <= 1'b0;
      push_pop_q <= 1'b0;
      uses_index_q <= 1'b0;
      disp_imm_q <= 1'b0;
      jmp_miss_q <= 1'b0;
      jmp_dword_q <= 1'b0;
      jmp_burst_q <= 1'b0;
      wr_cnt_q <= 2'h0;
      wbuf_full_q <= 1'b0;
      tlb_miss_q <= 1'b0;
      tlb_upd_q <= 2'h0;
      multi_q <= 1'b0;
    end
    else if (take)
    begin
      misalign_q <= insn_misalign_cnt;
      base_dep_q <= insn_base_dep;
      push_pop_q <= insn_push_pop_pair;
      uses_index_q <= insn_uses_index;
      disp_imm_q <= insn_disp_imm;
      jmp_miss_q <= insn_jmp_miss;
      jmp_dword_q <= insn_jmp_dword;
      jmp_burst_q <= insn_jmp_burst;
      wr_cnt_q <= insn_wr_cnt;
      wbuf_full_q <= insn_wbuf_full;
      tlb_miss_q <= insn_tlb_miss;
      tlb_upd_q <= insn_tlb_upd;
      multi_q <= insn_multi_unaligned;
    end
  end

  // stall qualifiers are cleared on completion so a stale flag cannot stall
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reads_q <= 1'b0;
      fill_miss_q <= 1'b0;
      fill_line_q <= 1'b0;
    end
    else if (take)
    begin
      reads_q <= insn_reads;
      fill_miss_q <= insn_fill_miss;
      fill_line_q <= insn_fill_line;
    end
    else if (state_q == ICC_ST_DONE)
    begin
      reads_q <= 1'b0;
      fill_miss_q <= 1'b0;
      fill_line_q <= 1'b0;
    end
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ICC_ST_IDLE:
      begin
        if (take)
          state_d = ICC_ST_STALL;
      end
      ICC_ST_STALL:
      begin
        if (!hold)
          state_d = ICC_ST_DONE;
      end
      ICC_ST_DONE:
      begin
        state_d = ICC_ST_IDLE;
      end
      default:
      begin
        state_d = ICC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= ICC_ST_IDLE;
    else
      state_q <= state_d;
  end

  // one clock per held cycle; saturates rather than wrapping on a stuck bus
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stall_cnt_q <= '0;
    else if (take)
      stall_cnt_q <= '0;
    else if (state_q == ICC_ST_STALL && hold && stall_cnt_q != '1)
      stall_cnt_q <= stall_cnt_q + `ICC_INVAL_CLKS;
  end

  always_comb
  begin
    base_eff = (core.kind == ICC_KIND_OTHER) ? base_q : core.dec_base;
    miss_eff = '0;
    if (data_miss_q)
    begin
      miss_eff = (core.kind == ICC_KIND_OTHER) ? miss_q : core.dec_miss;
      // penalty column assumes the fastest bus; slower first reads cost r-2 more
      if (miss_eff != '0 && BUS_R > `ICC_BUS_R_FAST)
        miss_eff = miss_eff + BUS_R - `ICC_BUS_R_FAST;
    end
    total_d = base_eff + miss_eff + core.adj_sum + stall_cnt_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      total_clks_q <= '0;
      stall_clks_q <= '0;
      kind_q <= ICC_KIND_OTHER;
      ext_sign_q <= 1'b0;
    end
    else if (state_q == ICC_ST_DONE)
    begin
      total_clks_q <= total_d;
      stall_clks_q <= stall_cnt_q;
      kind_q <= core.kind;
      ext_sign_q <= core.ext_sign;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      busy_q <= state_d != ICC_ST_IDLE;
      done_q <= state_q == ICC_ST_DONE;
    end
  end

endmodule // icc_clock_model

// File: test/icc_clock_checker.sv
// Purpose: port-level timing and decode checks for the clock-count model
// Assumes: bound to icc_clock_model, single clock domain
// Notes: the decoded opcode is captured at the accepting edge
`timescale 1ns/100ps

module icc_clock_checker
  import icc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic insn_valid,
  input wire logic [7:0] insn_op0,
  input wire logic [7:0] insn_op1,
  input wire logic fill_busy,
  input wire logic bus_avail,
  input wire logic inval_contend,
  input wire logic busy_q,
  input wire logic done_q,
  input wire icc_pkg::icc_clk_t stall_clks_q,
  input wire icc_pkg::icc_kind_e kind_q,
  input wire logic ext_sign_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] op0_q;
  logic [7:0] op1_q;
  icc_clk_t cnt_q;
  logic is_ext;
  logic take;
  // the model is idle again in the done cycle, so a request there is taken
  assign take = insn_valid && !busy_q;
  assign is_ext = op0_q == 8'h0f && (op1_q & 8'hf6) == 8'hb6;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      op0_q <= 8'h00;
      op1_q <= 8'h00;
    end
    else if (take)
    begin
      op0_q <= insn_op0;
      op1_q <= insn_op1;
    end
  // busy cycles of one instruction; two of them are the fixed overhead
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cnt_q <= 10'h000;
    else if (done_q)
      cnt_q <= 10'h000;
    else if (busy_q)
      cnt_q <= cnt_q + 10'h001;
  a_done_single: assert property (done_q |=> !done_q) else $error("done wider than one cycle");
  a_take_starts: assert property (take |=> busy_q) else $error("request not taken");
  a_idle_stays: assert property (!busy_q && !done_q && !insn_valid |=> !busy_q)
    else $error("busy without request");
  a_busy_ends: assert property ($fell(busy_q) |-> done_q) else $error("busy fell without done");
  a_fast_done: assert property (busy_q && !inval_contend && bus_avail && !fill_busy
    |-> ##[1:2] done_q) else $error("done late without stall");
  a_inval_holds: assert property ($rose(busy_q) && inval_contend |-> ##2 !done_q)
    else $error("invalidate did not stall");
  a_stall_match: assert property (done_q |-> stall_clks_q == cnt_q - 10'h002)
    else $error("stall count off");
  a_ext_decode: assert property (done_q && is_ext |-> kind_q == ICC_KIND_EXT
    && ext_sign_q == op1_q[3]) else $error("extending move decode wrong");
  a_lea_decode: assert property (done_q && op0_q == 8'h8d |-> kind_q == ICC_KIND_LEA)
    else $error("address load decode wrong");
  a_other_kind: assert property (done_q && !is_ext && op0_q != 8'h8d
    |-> kind_q == ICC_KIND_OTHER) else $error("undecoded opcode misreported");
  c_ext: cover property (done_q && kind_q == ICC_KIND_EXT);
  c_lea: cover property (done_q && kind_q == ICC_KIND_LEA);
  c_stall: cover property (done_q && stall_clks_q != 10'h000);
endmodule // icc_clock_checker

bind icc_clock_model icc_clock_checker u_chk (.clk(clk), .rst(rst), .insn_valid(insn_valid),
  .insn_op0(insn_op0), .insn_op1(insn_op1), .fill_busy(fill_busy), .bus_avail(bus_avail),
  .inval_contend(inval_contend), .busy_q(busy_q), .done_q(done_q),
  .stall_clks_q(stall_clks_q), .kind_q(kind_q), .ext_sign_q(ext_sign_q));

// File: test/tb_insn_clock_count_model.sv
// Purpose: self-checking bench for the clock-count model
// Assumes: bus timing 3-1-2, so the r-2 miss term is nonzero
// Notes: stall inputs are raised only while an instruction is in flight
`timescale 1ns/100ps

module tb_insn_clock_count_model;
  import icc_pkg::*;
  localparam icc_clk_t R = 10'h003;
  localparam icc_clk_t B = 10'h001;
  localparam icc_clk_t W = 10'h002;
  logic clk, rst, insn_valid, insn_mem_form, insn_data_miss, insn_base_dep, insn_push_pop_pair;
  logic insn_uses_index, insn_disp_imm, insn_jmp_miss, insn_jmp_dword, insn_jmp_burst;
  logic insn_wbuf_full, insn_tlb_miss, insn_multi_unaligned, insn_reads, insn_fill_miss;
  logic insn_fill_line, fill_busy, bus_avail, inval_contend, busy_q, done_q, ext_sign_q;
  logic [7:0] insn_op0, insn_op1;
  logic [1:0] insn_misalign_cnt, insn_wr_cnt, insn_tlb_upd;
  icc_clk_t insn_base_clks, insn_miss_clks, total_clks_q, stall_clks_q;
  icc_kind_e kind_q;
  int n_errors, total_checks, cycles;

  icc_clock_model #(.BUS_R(R), .BUS_B(B), .BUS_W(W)) u_dut (.clk, .rst, .insn_valid,
    .insn_op0, .insn_op1, .insn_mem_form, .insn_base_clks, .insn_miss_clks, .insn_data_miss,
    .insn_misalign_cnt, .insn_base_dep, .insn_push_pop_pair, .insn_uses_index, .insn_disp_imm,
    .insn_jmp_miss, .insn_jmp_dword, .insn_jmp_burst, .insn_wr_cnt, .insn_wbuf_full,
    .insn_tlb_miss, .insn_tlb_upd, .insn_multi_unaligned, .insn_reads, .insn_fill_miss,
    .insn_fill_line, .fill_busy, .bus_avail, .inval_contend, .busy_q, .done_q, .total_clks_q,
    .stall_clks_q, .kind_q, .ext_sign_q);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs under two hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk_clk(input icc_clk_t got, input icc_clk_t exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %0d want %0d", $time, what, got, exp);
    end
  endtask

  task automatic chk_kind(input icc_kind_e got, input icc_kind_e exp, input logic sg,
                          input logic se);
    total_checks++;
    if (got !== exp || sg !== se)
    begin
      n_errors++;
      $display("BAD %0t kind %0d sign %b", $time, got, sg);
    end
  endtask

  task automatic clr;
    {insn_mem_form, insn_data_miss, insn_base_dep, insn_push_pop_pair, insn_uses_index} = '0;
    {insn_disp_imm, insn_jmp_miss, insn_jmp_dword, insn_jmp_burst, insn_wbuf_full} = '0;
    {insn_tlb_miss, insn_multi_unaligned, insn_reads, insn_fill_miss, insn_fill_line} = '0;
    {insn_misalign_cnt, insn_wr_cnt, insn_tlb_upd} = '0;
    insn_op0 = 8'h90;
    insn_op1 = 8'h00;
    insn_base_clks = 10'h000;
    insn_miss_clks = 10'h000;
  endtask

  // hs selects the live stall cause held for nh cycles: invalidate, fill, bus
  task automatic run(input icc_clk_t et, input icc_clk_t es, input int nh, input logic [2:0] hs);
    int w;
    @(negedge clk);
    insn_valid = 1'b1;
    @(negedge clk);
    insn_valid = 1'b0;
    inval_contend = hs[0];
    fill_busy = hs[1];
    bus_avail = !hs[2];
    w = 0;
    // done stands one cycle, so it is watched while the stall inputs are still held
    while (done_q !== 1'b1 && w < nh + 20)
    begin
      @(negedge clk);
      w++;
      if (w == nh)
      begin
        inval_contend = 1'b0;
        fill_busy = 1'b0;
        bus_avail = 1'b1;
      end
    end
    if (w < nh)
    begin
      inval_contend = 1'b0;
      fill_busy = 1'b0;
      bus_avail = 1'b1;
    end
    chk_clk({9'h000, done_q}, 10'h001, "done");
    chk_clk(total_clks_q, et, "total");
    chk_clk(stall_clks_q, es, "stall");
  endtask

  task automatic t_ext;
    for (int i = 0; i < 4; i++)
    begin
      clr();
      insn_op0 = 8'h0f;
      insn_op1 = 8'hb6 | {4'h0, i[1], 2'b00, i[0]};
      insn_mem_form = i[0];
      insn_data_miss = i[0];
      run(i[0] ? 10'h005 + R - 10'h002 : 10'h003, 10'h000, 0, 3'b000);
      chk_kind(kind_q, ICC_KIND_EXT, ext_sign_q, i[1]);
    end
  endtask

  task automatic t_lea;
    for (int i = 0; i < 2; i++)
    begin
      clr();
      insn_op0 = 8'h8d;
      insn_uses_index = i[0];
      run(10'h001 + i[0], 10'h000, 0, 3'b000);
      chk_kind(kind_q, ICC_KIND_LEA, ext_sign_q, 1'b0);
    end
    clr();
    insn_op0 = 8'h0f;
    insn_op1 = 8'hb4;
    insn_base_clks = 10'h007;
    run(10'h007, 10'h000, 0, 3'b000);
    chk_kind(kind_q, ICC_KIND_OTHER, ext_sign_q, 1'b0);
  endtask

  task automatic t_adjust;
    clr();
    insn_base_clks = 10'h005;
    insn_misalign_cnt = 2'h3;
    run(10'h005 + 10'h003 * 10'h003, 10'h000, 0, 3'b000);
    clr();
    insn_base_clks = 10'h002;
    insn_base_dep = 1'b1;
    run(10'h003, 10'h000, 0, 3'b000);
    insn_push_pop_pair = 1'b1;
    run(10'h002, 10'h000, 0, 3'b000);
    clr();
    insn_base_clks = 10'h002;
    insn_uses_index = 1'b1;
    run(10'h003, 10'h000, 0, 3'b000);
    insn_disp_imm = 1'b1;
    run(10'h004, 10'h000, 0, 3'b000);
  endtask

  task automatic t_jump;
    clr();
    insn_base_clks = 10'h001;
    {insn_jmp_miss, insn_jmp_dword, insn_jmp_burst} = 3'b011;
    run(10'h001, 10'h000, 0, 3'b000);
    insn_jmp_miss = 1'b1;
    run(10'h001 + 10'h002 * R + 10'h006 * B, 10'h000, 0, 3'b000);
    insn_jmp_burst = 1'b0;
    run(10'h001 + R + 10'h003 * B, 10'h000, 0, 3'b000);
    insn_jmp_dword = 1'b0;
    run(10'h001 + R, 10'h000, 0, 3'b000);
  endtask

  task automatic t_mem;
    icc_clk_t tlb[3] = '{10'h00d, 10'h015, 10'h01c};
    clr();
    insn_base_clks = 10'h001;
    insn_wr_cnt = 2'h2;
    run(10'h001, 10'h000, 0, 3'b000);
    insn_wbuf_full = 1'b1;
    run(10'h001 + 10'h002 * W, 10'h000, 0, 3'b000);
    clr();
    insn_tlb_miss = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      insn_tlb_upd = i[1:0];
      run(tlb[i], 10'h000, 0, 3'b000);
    end
    clr();
    insn_base_clks = 10'h004;
    insn_miss_clks = 10'h002;
    insn_multi_unaligned = 1'b1;
    run(10'h004, 10'h000, 0, 3'b000);
    insn_data_miss = 1'b1;
    run(10'h004 + R + R + 10'h003 * B, 10'h000, 0, 3'b000);
  endtask

  task automatic t_stall;
    clr();
    insn_base_clks = 10'h002;
    run(10'h005, 10'h003, 3, 3'b001);
    run(10'h002, 10'h000, 3, 3'b010);
    insn_fill_line = 1'b1;
    run(10'h004, 10'h002, 2, 3'b010);
    clr();
    insn_base_clks = 10'h002;
    insn_fill_miss = 1'b1;
    run(10'h003, 10'h001, 1, 3'b010);
    clr();
    insn_base_clks = 10'h002;
    insn_reads = 1'b1;
    run(10'h006, 10'h004, 4, 3'b100);
  endtask

  // reset in mid-flight must clear every result and leave the model idle
  task automatic t_reset;
    clr();
    insn_op0 = 8'h0f;
    insn_op1 = 8'hbe;
    run(10'h003, 10'h000, 0, 3'b000);
    chk_kind(kind_q, ICC_KIND_EXT, ext_sign_q, 1'b1);
    @(negedge clk);
    insn_valid = 1'b1;
    @(negedge clk);
    insn_valid = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    chk_clk({9'h000, busy_q}, 10'h000, "busy in reset");
    chk_clk(total_clks_q, 10'h000, "total in reset");
    chk_clk(stall_clks_q, 10'h000, "stall in reset");
    chk_kind(kind_q, ICC_KIND_OTHER, ext_sign_q, 1'b0);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    clr();
    insn_base_clks = 10'h002;
    run(10'h002, 10'h000, 0, 3'b000);
  endtask

  initial
  begin
    rst = 1'b1;
    insn_valid = 1'b0;
    fill_busy = 1'b0;
    bus_avail = 1'b1;
    inval_contend = 1'b0;
    clr();
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_ext();
    t_lea();
    t_adjust();
    t_jump();
    t_mem();
    t_stall();
    t_reset();
    wrap_up();
  end
endmodule // tb_insn_clock_count_model
